// File: src/cgs_clock_gen_status.sv
// Clock generator status and control registers behind an AXI4-Lite slave
`timescale 1ns/100ps

module cgs_clock_gen_status (
   // Clock and reset
   input  wire logic                  ref_clk_i,
   input  wire logic                  srst_i,
   // AXI4-Lite write address and data
   input  wire logic [7:0]            s_axi_awaddr_i,
   input  wire logic                  s_axi_awvalid_i,
   output logic                       s_axi_awready_o,
   input  wire logic [31:0]           s_axi_wdata_i,
   input  wire logic [3:0]            s_axi_wstrb_i,
   input  wire logic                  s_axi_wvalid_i,
   output logic                       s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0]                 s_axi_bresp_o,
   output logic                       s_axi_bvalid_o,
   input  wire logic                  s_axi_bready_i,
   // AXI4-Lite read
   input  wire logic [7:0]            s_axi_araddr_i,
   input  wire logic                  s_axi_arvalid_i,
   output logic                       s_axi_arready_o,
   output logic [31:0]                s_axi_rdata_o,
   output logic [1:0]                 s_axi_rresp_o,
   output logic                       s_axi_rvalid_o,
   input  wire logic                  s_axi_rready_i,
   // Generator feedback and system state
   input  wire logic                  loop_locked_i,
   input  wire logic                  fll_active_i,
   input  wire logic                  pll_active_i,
   input  wire logic                  stop_mode_i,
   input  wire logic                  debug_mode_i,
   input  wire logic                  factory_trim_i,
   // Settings applied to the generator
   output cgs_pkg::cgs_clk_sel_t      gen_sel_o,
   output logic                       dco_max_setting_o,
   output logic [1:0]                 dco_range_select_o,
   output logic                       extra_ref_divider_o,
   output logic                       external_ref_select_o,
   output logic                       low_power_o,
   output logic [7:0]                 trim_o,
   output logic [2:0]                 reference_divider_o,
   output logic [3:0]                 vco_divider_o,
   output logic                       fine_trim_bit_o,
   // Status
   output logic                       lock_o,
   output logic                       loss_of_lock_flag_o,
   output logic                       loss_of_lock_irq_o
);

   cgs_pkg::cgs_state_t s;
   cgs_pkg::cgs_state_t next_s;

   logic        do_write;
   logic        lock_det_en;
   logic        in_lp;
   logic        fll_mode;
   logic        ext_fll;
   logic        int_fll;
   logic        pll_mode;
   logic        cfg_hit;
   logic        lol_set;
   logic        lol_clr;
   logic        restart;
   logic [7:0]  status_byte;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);

   // ----------------------------------------------------------------
   // Mode decode and status image
   // ----------------------------------------------------------------

   // Modes are judged from the state the generator reports back
   assign fll_mode    = ~s.bck2.loop_src;
   assign pll_mode    = s.bck2.loop_src;
   assign ext_fll     = fll_mode & ~s.bck2.ref_src;
   assign int_fll     = fll_mode & s.bck2.ref_src;
   assign lock_det_en = fll_active_i | pll_active_i;
   // Bypass clock modes with low power set, or stop
   assign in_lp = stop_mode_i | (s.low_power & ((s.bck2.clk_mode == cgs_pkg::MODE_INT) |
                                             (s.bck2.clk_mode == cgs_pkg::MODE_EXT)));

   // Loop, reference and mode status fields come only from the returned state, never the selects
   always_comb begin
      status_byte = 8'h00;
      status_byte[cgs_pkg::LOL_BIT] = s.lol;
      status_byte[cgs_pkg::LOCK_BIT] = s.lock;
      status_byte[cgs_pkg::LOOP_ST_BIT] = s.bck2.loop_src;
      status_byte[cgs_pkg::REF_ST_BIT] = s.bck2.ref_src;
      status_byte[cgs_pkg::MODE_ST_LSB +: 2] = s.bck2.clk_mode;
      status_byte[cgs_pkg::FINE_TRIM_BIT] = s.fine_trim;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------

   // Whole block in one pass: bus, registers, crossing, lock tracking
   always_comb begin
      next_s = s;
      do_write = ~s.awready & ~s.wready & ~s.bvalid;
      lol_clr = 1'b0;

      // Address and data are taken independently, in either order
      if (s.awready && s_axi_awvalid_i) begin
         next_s.awaddr = s_axi_awaddr_i;
         next_s.awready = 1'b0;
      end
      if (s.wready && s_axi_wvalid_i) begin
         next_s.wdata = s_axi_wdata_i;
         next_s.wstrb = s_axi_wstrb_i;
         next_s.wready = 1'b0;
      end

      // Register write once both halves are held
      if (do_write) begin
         next_s.bvalid = 1'b1;
         next_s.bresp = cgs_pkg::RESP_OKAY;
         unique case (s.awaddr)
            cgs_pkg::ADDR_STATUS: begin
               // Only the flag and the fine trim bit are writable
               if (s.wstrb[0]) begin
                  lol_clr = s.wdata[cgs_pkg::LOL_BIT];
                  next_s.fine_trim = s.wdata[cgs_pkg::FINE_TRIM_BIT];
               end
            end
            cgs_pkg::ADDR_CTRL: begin
               if (s.wstrb[0]) begin
                  next_s.sel.clk_mode = s.wdata[cgs_pkg::MODE_SEL_LSB +: 2];
                  next_s.sel.ref_src = s.wdata[cgs_pkg::REF_SEL_BIT];
                  next_s.sel.loop_src = s.wdata[cgs_pkg::LOOP_SEL_BIT];
                  next_s.irq_en = s.wdata[cgs_pkg::IRQ_EN_BIT];
                  next_s.dmx = s.wdata[cgs_pkg::DMX_BIT];
                  next_s.dco_range = s.wdata[cgs_pkg::DCO_RANGE_LSB +: 2];
               end
               if (s.wstrb[1]) begin
                  next_s.extra_div = s.wdata[cgs_pkg::EXTRA_DIV_BIT];
                  next_s.ext_ref = s.wdata[cgs_pkg::EXT_REF_BIT];
                  next_s.low_power = s.wdata[cgs_pkg::LP_BIT];
               end
            end
            cgs_pkg::ADDR_DIV: begin
               if (s.wstrb[0]) begin
                  next_s.trim = s.wdata[cgs_pkg::TRIM_LSB +: 8];
               end
               if (s.wstrb[1]) begin
                  next_s.ref_div = s.wdata[cgs_pkg::REF_DIV_LSB +: 3];
                  next_s.vco_div = s.wdata[cgs_pkg::VCO_DIV_LSB +: 4];
               end
            end
            default: begin
               next_s.bresp = cgs_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Response taken: reopen both write channels
      if (s.bvalid && s_axi_bready_i) begin
         next_s.bvalid = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
      end

      // Read answered one cycle after the address is taken
      if (s.arready && s_axi_arvalid_i) begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rresp = cgs_pkg::RESP_OKAY;
         next_s.rdata = 32'h0000_0000;
         unique case (s_axi_araddr_i)
            cgs_pkg::ADDR_STATUS: next_s.rdata[7:0] = status_byte;
            cgs_pkg::ADDR_CTRL: begin
               next_s.rdata[cgs_pkg::MODE_SEL_LSB +: 2] = s.sel.clk_mode;
               next_s.rdata[cgs_pkg::REF_SEL_BIT] = s.sel.ref_src;
               next_s.rdata[cgs_pkg::LOOP_SEL_BIT] = s.sel.loop_src;
               next_s.rdata[cgs_pkg::IRQ_EN_BIT] = s.irq_en;
               next_s.rdata[cgs_pkg::DMX_BIT] = s.dmx;
               next_s.rdata[cgs_pkg::DCO_RANGE_LSB +: 2] = s.dco_range;
               next_s.rdata[cgs_pkg::EXTRA_DIV_BIT] = s.extra_div;
               next_s.rdata[cgs_pkg::EXT_REF_BIT] = s.ext_ref;
               next_s.rdata[cgs_pkg::LP_BIT] = s.low_power;
            end
            cgs_pkg::ADDR_DIV: begin
               next_s.rdata[cgs_pkg::TRIM_LSB +: 8] = s.trim;
               next_s.rdata[cgs_pkg::REF_DIV_LSB +: 3] = s.ref_div;
               next_s.rdata[cgs_pkg::VCO_DIV_LSB +: 4] = s.vco_div;
            end
            default: next_s.rresp = cgs_pkg::RESP_SLVERR;
         endcase
      end
      if (s.rvalid && s_axi_rready_i) begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end

      // Two flops forward into the generator, two back to status
      next_s.fwd1 = s.sel;
      next_s.fwd2 = s.fwd1;
      next_s.bck1 = s.fwd2;
      next_s.bck2 = s.bck1;

      // Settings whose change forces the loop to prove lock again
      cfg_hit = (next_s.sel.loop_src != s.sel.loop_src) |
                (fll_mode & ((next_s.dmx != s.dmx) | (next_s.dco_range != s.dco_range) |
                             (next_s.sel.ref_src != s.sel.ref_src))) |
                (ext_fll & (next_s.extra_div != s.extra_div)) |
                (int_fll & (next_s.trim != s.trim)) |
                ((ext_fll | pll_mode) & (next_s.ref_div != s.ref_div)) |
                (pll_mode & (next_s.vco_div != s.vco_div));

      // Lock needs the detector high for a full relock window
      restart = ~lock_det_en | in_lp | cfg_hit | ~loop_locked_i;
      if (restart) begin
         next_s.relock_cnt = 8'h00;
      end else if (s.relock_cnt != cgs_pkg::RELOCK_CYCLES) begin
         next_s.relock_cnt = s.relock_cnt + 8'h01;
      end
      next_s.lock = (next_s.relock_cnt == cgs_pkg::RELOCK_CYCLES);

      // Commanded unlock is not a loss; a new loss beats a clear
      lol_set = s.lock & lock_det_en & ~loop_locked_i & ~in_lp;
      next_s.lol = lol_set | (s.lol & ~lol_clr);
      next_s.irq = next_s.lol & next_s.irq_en;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // Fine trim is caught while reset is held, from the strap level, or from FINE_TRIM_DEBUG in debug mode
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         s <= '0;
         s.awready <= 1'b1;
         s.wready <= 1'b1;
         s.arready <= 1'b1;
         s.sel.ref_src <= 1'b1;
         s.fwd1.ref_src <= 1'b1;
         s.fwd2.ref_src <= 1'b1;
         s.bck1.ref_src <= 1'b1;
         s.bck2.ref_src <= 1'b1;
         s.trim <= cgs_pkg::TRIM_RST;
         s.ref_div <= cgs_pkg::REF_DIV_RST;
         s.vco_div <= cgs_pkg::VCO_DIV_RST;
         s.fine_trim <= debug_mode_i ? cgs_pkg::FINE_TRIM_DEBUG : factory_trim_i;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all from the state register
   // ----------------------------------------------------------------
   assign s_axi_awready_o       = s.awready;
   assign s_axi_wready_o        = s.wready;
   assign s_axi_bresp_o         = s.bresp;
   assign s_axi_bvalid_o        = s.bvalid;
   assign s_axi_arready_o       = s.arready;
   assign s_axi_rdata_o         = s.rdata;
   assign s_axi_rresp_o         = s.rresp;
   assign s_axi_rvalid_o        = s.rvalid;
   assign gen_sel_o             = s.fwd2;
   assign dco_max_setting_o     = s.dmx;
   assign dco_range_select_o    = s.dco_range;
   assign extra_ref_divider_o   = s.extra_div;
   assign external_ref_select_o = s.ext_ref;
   assign low_power_o           = s.low_power;
   assign trim_o                = s.trim;
   assign reference_divider_o   = s.ref_div;
   assign vco_divider_o         = s.vco_div;
   assign fine_trim_bit_o       = s.fine_trim;
   assign lock_o                = s.lock;
   assign loss_of_lock_flag_o   = s.lol;
   assign loss_of_lock_irq_o    = s.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   sequence sel_moved;
      s.sel != $past(s.sel);
   endsequence

   sequence sel_settled;
      (s.sel == $past(s.sel)) [*4];
   endsequence

   AST_LOL_SET: assert property (
      lol_set |=> s.lol)
      else $error("loss of lock not flagged");

   AST_IRQ_GATE: assert property (
      s.irq |-> (s.lol && s.irq_en) ##1 (s.irq == (s.lol && s.irq_en)))
      else $error("interrupt request not gated by enable");

   AST_LOL_W1C: assert property (
      (lol_clr && !lol_set) |=> !s.lol)
      else $error("flag not cleared by write of one");

   AST_LOL_HOLD: assert property (
      (s.lol && !lol_clr) |=> s.lol)
      else $error("flag lost without a clearing write");

   AST_DET_OFF: assert property (
      (!fll_active_i && !pll_active_i) |=> !s.lock)
      else $error("lock shown with both loops off");

   AST_CFG_CLR: assert property (
      cfg_hit |=> !s.lock)
      else $error("lock kept across a settings change");

   AST_LP_CLR: assert property (
      in_lp |=> !s.lock)
      else $error("lock kept in low power or stop");

   AST_SYNC_STATUS: assert property (
      sel_moved ##1 sel_settled |-> (s.bck2 == s.sel))
      else $error("status did not follow select after crossing");

   AST_NOT_EARLY: assert property (
      sel_moved |-> (s.bck2 == $past(s.bck1)) ##1 (s.bck2 != s.sel || s.bck1 == s.sel))
      else $error("status moved in the cycle of the select write");

   AST_FWD: assert property (
      (s.fwd2 == $past(s.sel, 2)) && (s.bck2 == $past(s.fwd2, 2)))
      else $error("select crossing depth wrong");

   AST_TRIM_LOAD: assert property (
      $past(srst_i) |-> (s.fine_trim == ($past(debug_mode_i) ? cgs_pkg::FINE_TRIM_DEBUG
                                                             : $past(factory_trim_i))))
      else $error("fine trim not loaded at reset");

endmodule

// File: common/cgs_pkg.sv
// Package: register map, field layout, reset values and timing of the clock generator status block
package cgs_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CTRL   = 8'h04;
   localparam logic [7:0] ADDR_DIV    = 8'h08;

   // ----------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------
   localparam int LOL_BIT      = 7;
   localparam int LOCK_BIT     = 6;
   localparam int LOOP_ST_BIT  = 5;
   localparam int REF_ST_BIT   = 4;
   localparam int MODE_ST_LSB  = 2;
   localparam int FINE_TRIM_BIT = 0;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int MODE_SEL_LSB = 0;
   localparam int REF_SEL_BIT  = 2;
   localparam int LOOP_SEL_BIT = 3;
   localparam int IRQ_EN_BIT   = 4;
   localparam int DMX_BIT      = 5;
   localparam int DCO_RANGE_LSB = 6;
   localparam int EXTRA_DIV_BIT = 8;
   localparam int EXT_REF_BIT  = 9;
   localparam int LP_BIT       = 10;

   // ----------------------------------------------------------------
   // Divider register fields
   // ----------------------------------------------------------------
   localparam int TRIM_LSB     = 0;
   localparam int REF_DIV_LSB  = 8;
   localparam int VCO_DIV_LSB  = 12;

   // ----------------------------------------------------------------
   // Clock mode encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_FLL = 2'h0;
   localparam logic [1:0] MODE_INT = 2'h1;
   localparam logic [1:0] MODE_EXT = 2'h2;
   localparam logic [1:0] MODE_PLL = 2'h3;
   localparam logic [7:0] TRIM_RST = 8'h80;
   localparam logic [2:0] REF_DIV_RST = 3'h0;
   localparam logic [3:0] VCO_DIV_RST = 4'h1;
   localparam logic       FINE_TRIM_DEBUG = 1'h0;

   // ----------------------------------------------------------------
   // Bus responses and timing
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CLK_PERIOD_NS = 100;
   localparam int RELOCK_TIME_NS = 10000;
   localparam logic [7:0] RELOCK_CYCLES =
      8'((RELOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Selection carried across to the generator and back
   typedef struct packed {
      logic       loop_src;
      logic       ref_src;
      logic [1:0] clk_mode;
   } cgs_clk_sel_t;

   // Whole state of the block
   typedef struct packed {
      logic         awready;
      logic         wready;
      logic         arready;
      logic [7:0]   awaddr;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         rvalid;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
      cgs_clk_sel_t sel;
      logic         irq_en;
      logic         dmx;
      logic [1:0]   dco_range;
      logic         extra_div;
      logic         ext_ref;
      logic         low_power;
      logic [7:0]   trim;
      logic [2:0]   ref_div;
      logic [3:0]   vco_div;
      logic         fine_trim;
      cgs_clk_sel_t fwd1;
      cgs_clk_sel_t fwd2;
      cgs_clk_sel_t bck1;
      cgs_clk_sel_t bck2;
      logic         lol;
      logic         lock;
      logic [7:0]   relock_cnt;
      logic         irq;
   } cgs_state_t;

endpackage

// File: test/cgs_testbench.sv
// Self-checking bench for the clock generator status block
`timescale 1ns/100ps
module testbench;
   // ----
   // Bench signals
   // ----
   logic                  ref_clk_i, srst_i;
   logic [7:0]            awaddr, araddr;
   logic [31:0]           wdata, rdata;
   logic [3:0]            wstrb;
   logic                  awvalid, wvalid, bready, arvalid, rready;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [1:0]            bresp, rresp;
   logic                  locked, fll_on, pll_on, stop, dbg, trim_strap;
   cgs_pkg::cgs_clk_sel_t gen_sel;
   logic                  lock, lol, irq;
   int                    failures, comparisons;

   // 10 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   cgs_clock_gen_status dut (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .loop_locked_i(locked),
      .fll_active_i(fll_on), .pll_active_i(pll_on), .stop_mode_i(stop),
      .debug_mode_i(dbg), .factory_trim_i(trim_strap), .gen_sel_o(gen_sel),
      .dco_max_setting_o(), .dco_range_select_o(), .extra_ref_divider_o(),
      .external_ref_select_o(), .low_power_o(), .trim_o(), .reference_divider_o(),
      .vco_divider_o(), .fine_trim_bit_o(), .lock_o(lock),
      .loss_of_lock_flag_o(lol), .loss_of_lock_irq_o(irq));

   // ----
   // Reporting and bus tasks
   // ----
   task automatic close_out();
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // A hung handshake ends the run here
   task automatic timeout();
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      close_out();
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, haw, hw, hb;
      logic [1:0] r;
      int n;
      aw = 1'b0;
      w = 1'b0;
      n = 0;
      @(posedge ref_clk_i);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         #1;
         haw = awvalid & awready;
         hw = wvalid & wready;
         @(posedge ref_clk_i);
         if (haw) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         aw = aw | haw;
         w = w | hw;
         if (++n > 50) timeout();
      end while (!(aw && w));
      do begin
         #1;
         hb = bvalid;
         r = bresp;
         @(posedge ref_clk_i);
         if (++n > 100) timeout();
      end while (!hb);
      bready <= 1'b0;
      chk({30'h0, r}, {30'h0, er});
   endtask

   // Read, then compare masked data and response
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
      logic har, hr;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      @(posedge ref_clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         #1;
         har = arvalid & arready;
         @(posedge ref_clk_i);
         if (har) arvalid <= 1'b0;
         if (++n > 50) timeout();
      end while (!har);
      do begin
         #1;
         hr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge ref_clk_i);
         if (++n > 100) timeout();
      end while (!hr);
      rready <= 1'b0;
      chk(d & m, e);
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic wait_lock(input int bound);
      int n;
      n = 0;
      while (lock !== 1'b1) begin
         @(posedge ref_clk_i);
         #1;
         if (++n > bound) timeout();
      end
   endtask

   task automatic do_reset();
      @(posedge ref_clk_i) srst_i <= 1'b1;
      repeat (10) @(posedge ref_clk_i);
      srst_i <= 1'b0;
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_reset();
      rdc(8'h00, 32'hffffffff, 32'h11, 2'h0);
      rdc(8'h04, 32'hffffffff, 32'h4, 2'h0);
      rdc(8'h08, 32'hffffffff, 32'h1080, 2'h0);
      rdc(8'h0c, 32'hffffffff, 32'h0, 2'h2);
      wr(8'h0c, 32'hffffffff, 2'h2);
   endtask

   task automatic t_lock();
      @(posedge ref_clk_i) locked <= 1'b1;
      wait_lock(130);
      @(posedge ref_clk_i) locked <= 1'b0;
      @(posedge ref_clk_i);
      #1;
      chk(lock, 1'b0);
      chk(lol, 1'b1);
      chk(irq, 1'b0);
      wr(8'h00, 32'h0, 2'h0);
      rdc(8'h00, 32'h80, 32'h80, 2'h0);
      wr(8'h04, 32'h14, 2'h0);
      chk(irq, 1'b1);
      // Flag cleared, status bits must ignore the ones
      wr(8'h00, 32'hfd, 2'h0);
      rdc(8'h00, 32'hfc, 32'h10, 2'h0);
      chk(irq, 1'b0);
   endtask

   task automatic t_restart();
      @(posedge ref_clk_i) locked <= 1'b1;
      wait_lock(130);
      wr(8'h04, 32'h44, 2'h0);
      @(posedge ref_clk_i);
      #1;
      chk(lock, 1'b0);
      chk(lol, 1'b0);
      wait_lock(130);
      wr(8'h04, 32'h4c, 2'h0);
      @(posedge ref_clk_i);
      #1;
      chk(lock, 1'b0);
      wr(8'h04, 32'h4, 2'h0);
      wait_lock(130);
   endtask

   task automatic t_stop();
      @(posedge ref_clk_i) stop <= 1'b1;
      repeat (150) @(posedge ref_clk_i);
      #1;
      chk(lock, 1'b0);
      @(posedge ref_clk_i) stop <= 1'b0;
      wait_lock(130);
      // Low power with a bypass clock mode drops lock but is no loss of lock
      wr(8'h04, 32'h405, 2'h0);
      repeat (8) @(posedge ref_clk_i);
      #1;
      chk(lock, 1'b0);
      chk(lol, 1'b0);
      wr(8'h04, 32'h4, 2'h0);
      wait_lock(130);
      @(posedge ref_clk_i) fll_on <= 1'b0;
      repeat (150) @(posedge ref_clk_i);
      #1;
      chk(lock, 1'b0);
      @(posedge ref_clk_i) fll_on <= 1'b1;
      wait_lock(130);
   endtask

   task automatic t_sel();
      logic [1:0] m;
      logic r, l;
      logic [31:0] prev;
      prev = 32'h10;
      for (int k = 0; k < 4; k++) begin
         m = 2'(k);
         r = m[0];
         l = ~m[1];
         wr(8'h04, {28'h0, l, r, m}, 2'h0);
         rdc(8'h00, 32'h3c, prev, 2'h0);
         repeat (4) @(posedge ref_clk_i);
         prev = {26'h0, l, r, m, 2'h0};
         rdc(8'h00, 32'h3c, prev, 2'h0);
         chk(32'(gen_sel), {28'h0, l, r, m});
      end
   endtask

   // Debug reset must not take the factory trim
   task automatic t_debug();
      dbg <= 1'b1;
      do_reset();
      rdc(8'h00, 32'h1, 32'h0, 2'h0);
      dbg <= 1'b0;
      do_reset();
      rdc(8'h00, 32'h1, 32'h1, 2'h0);
   endtask

   // ----
   // Main sequence
   // ----
   initial begin
      failures = 0;
      comparisons = 0;
      srst_i = 1'b1;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {locked, pll_on, stop, dbg} = '0;
      fll_on = 1'b1;
      trim_strap = 1'b1;
      do_reset();
      t_reset();
      t_lock();
      t_restart();
      t_stop();
      t_sel();
      t_debug();
      close_out();
   end
endmodule
